// ===== logic/chan_mode_ctrl.sv
// four capture/compare channel mode logic with an axi4-lite register slave
// assumes counter value, direction, overflow and trigger pulses come from the timer core
// Summary of operation
// RQ1: code 000 disconnects reference; 001 sets, 010 clears, 011 toggles on match.
// RQ2: code 100 forces reference low, 101 forces it high.
// RQ3: pwm a: up high while data above counter; down low while below.
// RQ4: pwm b gives the inverse of pwm a in both directions.
// RQ5: except code 000, output follows reference xor polarity.
// RQ6: buffering off: written data compares immediately.
// RQ7: buffering on: written data waits in shadow until overflow.
// RQ8: pwm with immediate bit: trigger drives output without waiting for comparison.
// RQ9: config 00 output, 01 own filtered pin, 10 neighbour filtered input.
// RQ10: config 11 routes slave trigger input; software needs internal trigger selected.
// RQ11: software changes direction and source only while channel is disabled.
// RQ12: channels 1 and 2 swap filtered inputs under config 10.
// RQ13: channels 3 and 4 swap filtered inputs under config 10.
// RQ14: filter passes an edge after n consecutive equal samples.
// RQ15: code 0000 unfiltered at dead-time clock; 0001-0011 kernel clock, n 2,4,8.
// RQ16: codes 0100-1001 sample dead-time clock /2,/4,/8 with n 6 and 8.
// RQ17: codes 1010-1100 /16 n 5,6,8; 1110,1111 /32 n 6,8.
// RQ18: capture prescaler captures every 1st, 2nd, 4th or 8th active edge.
// RQ19: prescaler count cleared while channel enable is low.
// RQ20: odd channel in low byte, even in high; fields per mode.
// RQ21: with switch enable, high external clear input clears reference.
// RQ22: input mode captures counter into data at each prescaled event.
// RQ23: polarity 0 rising edge active, 1 falling edge with inverted input.
// RQ24: filter code 1101 samples at dead-time clock /32 with n 5.
module chan_mode_ctrl
  import chan_mode_pkg::*;
#(
  parameter int CH = 4
)
(
  // clock and reset
  input  wire logic          ref_clk_i,
  input  wire logic          reset_n_i,
  // axi4-lite slave
  input  wire logic [7:0]    s_axi_awaddr_i,
  input  wire logic          s_axi_awvalid_i,
  output logic               s_axi_awready_o,
  input  wire logic [31:0]   s_axi_wdata_i,
  input  wire logic [3:0]    s_axi_wstrb_i,
  input  wire logic          s_axi_wvalid_i,
  output logic               s_axi_wready_o,
  output logic [1:0]         s_axi_bresp_o,
  output logic               s_axi_bvalid_o,
  input  wire logic          s_axi_bready_i,
  input  wire logic [7:0]    s_axi_araddr_i,
  input  wire logic          s_axi_arvalid_i,
  output logic               s_axi_arready_o,
  output logic [31:0]        s_axi_rdata_o,
  output logic [1:0]         s_axi_rresp_o,
  output logic               s_axi_rvalid_o,
  input  wire logic          s_axi_rready_i,
  // timer core
  input  wire logic [15:0]   counter_value_i,
  input  wire logic          count_direction_i,
  input  wire logic          overflow_event_i,
  input  wire logic          trigger_event_i,
  input  wire logic          dead_time_tick_i,
  input  wire logic          slave_trigger_input_i,
  input  wire logic          external_clear_input_i,
  // pins and output stage
  input  wire logic [CH-1:0] channel_input_signal_i,
  output logic [CH-1:0]      raw_compare_reference_o,
  output logic [CH-1:0]      channel_output_o,
  output logic [CH-1:0]      capture_event_o
);

  logic [15:0]     mode_r [2];
  logic [15:0]     ctrl_r;
  logic [15:0]     shadow_r [CH];
  logic [15:0]     active_r [CH];
  logic [CH-1:0]   filt_r;
  logic [CH-1:0]   raw_r;
  logic [CH-1:0]   ref_en_r;
  logic [CH-1:0]   cap_r;
  logic [CH-1:0]   capflag_r;
  logic [CH-1:0]   prev_r;
  logic [2:0]      pre_r [CH];
  logic [3:0]      run_r [CH];
  logic [4:0]      dts_r;
  logic [5:0]      tdiv_r [CH];
  bus_state_t      wr_st_r;
  bus_state_t      rd_st_r;
  logic            aw_ok_r;
  logic            w_ok_r;
  logic [7:0]      aw_r;
  logic [31:0]     wd_r;
  logic [3:0]      ws_r;
  chan_set_t       set [CH];
  logic [CH-1:0]   en;
  logic [CH-1:0]   pol;
  logic [CH-1:0]   sel_in;
  logic            wr_go;
  logic [CH-1:0]   data_wr;

  // odd channel low byte, even channel high byte; input fields overlay output ones
  always_comb
  begin
    for (int i = 0; i < CH; i++)
    begin
      set[i] = chan_set_t'({mode_r[i/2][(i%2)*8 + FILT_LSB +: 4],
                            mode_r[i/2][(i%2)*8 + DIV_LSB +: 2],
                            mode_r[i/2][(i%2)*8 +: 8]}); // see RQ20
      en[i]  = ctrl_r[i*CTRL_STRIDE + CTRL_EN_BIT];
      pol[i] = ctrl_r[i*CTRL_STRIDE + CTRL_POL_BIT];
    end
  end

  // input routing: pairs are (0,1) and (2,3)
  always_comb
  begin
    for (int i = 0; i < CH; i++)
    begin
      case (set[i].cfg)
        CFG_OWN:  sel_in[i] = filt_r[i]; // see RQ9
        CFG_PAIR: sel_in[i] = filt_r[i ^ 1]; // see RQ12 see RQ13
        CFG_TRIG: sel_in[i] = slave_trigger_input_i; // see RQ10
        default:  sel_in[i] = 1'b0;
      endcase
    end
  end

  // free dead-time divider shared by all filters
  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      dts_r <= '0;
    else if (dead_time_tick_i)
      dts_r <= dts_r + 5'd1;
  end

  // digital filter, polarity applied before so falling edge looks rising
  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      filt_r <= '0;
      for (int i = 0; i < CH; i++)
        run_r[i] <= '0;
      for (int i = 0; i < CH; i++)
        tdiv_r[i] <= '0;
    end
    else
    begin
      for (int i = 0; i < CH; i++)
      begin
        tdiv_r[i] <= filt_div(set[i].filt);
        if (set[i].filt == 4'h0)
        begin
          if (dead_time_tick_i)
            filt_r[i] <= channel_input_signal_i[i] ^ pol[i]; // see RQ15 see RQ23
        end
        else if ((set[i].filt[3:2] == 2'b00) ||
                 (dead_time_tick_i && ((dts_r & tdiv_r[i][4:0]) == 5'd0))) // see RQ16 see RQ17 see RQ24
        begin
          if ((channel_input_signal_i[i] ^ pol[i]) == filt_r[i])
            run_r[i] <= '0;
          else if (run_r[i] + 4'd1 >= filt_n(set[i].filt))
          begin
            filt_r[i] <= ~filt_r[i]; // see RQ14
            run_r[i]  <= '0;
          end
          else
            run_r[i] <= run_r[i] + 4'd1;
        end
      end
    end
  end

  // capture prescaler and capture into data register
  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      prev_r <= '0;
      cap_r  <= '0;
      for (int i = 0; i < CH; i++)
        pre_r[i] <= '0;
    end
    else
    begin
      prev_r <= sel_in;
      for (int i = 0; i < CH; i++)
      begin
        cap_r[i] <= 1'b0;
        if (!en[i] || set[i].cfg == CFG_OUT)
          pre_r[i] <= '0; // see RQ19
        else if (sel_in[i] && !prev_r[i])
        begin
          if (pre_r[i] == 3'((1 << set[i].div) - 1))
          begin
            pre_r[i] <= '0;
            cap_r[i] <= 1'b1; // see RQ18
          end
          else
            pre_r[i] <= pre_r[i] + 3'd1;
        end
      end
    end
  end

  // data registers: shadow is what software sees in output mode
  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      for (int i = 0; i < CH; i++)
      begin
        shadow_r[i] <= DATA_RESET;
        active_r[i] <= DATA_RESET;
      end
    else
      for (int i = 0; i < CH; i++)
      begin
        if (set[i].cfg != CFG_OUT && cap_r[i])
        begin
          shadow_r[i] <= counter_value_i; // see RQ22
          active_r[i] <= counter_value_i;
        end
        else if (data_wr[i])
        begin
          shadow_r[i] <= wd_r[15:0];
          if (!set[i].buf_en)
            active_r[i] <= wd_r[15:0]; // see RQ6
        end
        else if (set[i].buf_en && overflow_event_i)
          active_r[i] <= shadow_r[i]; // see RQ7
      end
  end

  // raw reference generation
  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      raw_r    <= '0;
      ref_en_r <= '0;
    end
    else
      for (int i = 0; i < CH; i++)
      begin
        ref_en_r[i] <= (set[i].cfg == CFG_OUT) && (set[i].octrl != OC_OFF) && en[i]; // see RQ5
        if (set[i].sw_en && external_clear_input_i)
          raw_r[i] <= 1'b0; // see RQ21
        else
          case (set[i].octrl)
            OC_SET:    if (counter_value_i == active_r[i]) raw_r[i] <= 1'b1; // see RQ1
            OC_CLR:    if (counter_value_i == active_r[i]) raw_r[i] <= 1'b0; // see RQ1
            OC_TOGGLE: if (counter_value_i == active_r[i]) raw_r[i] <= ~raw_r[i]; // see RQ1
            OC_LOW:    raw_r[i] <= 1'b0; // see RQ2
            OC_HIGH:   raw_r[i] <= 1'b1; // see RQ2
            OC_PWM_A, OC_PWM_B:
            begin
              // immediate mode: trigger forces the active level without comparison
              if (set[i].imm_en && trigger_event_i)
                raw_r[i] <= (set[i].octrl == OC_PWM_A); // see RQ8
              else if (!count_direction_i)
                raw_r[i] <= (active_r[i] > counter_value_i) ^ set[i].octrl[0]; // see RQ3 see RQ4
              else
                raw_r[i] <= !(active_r[i] < counter_value_i) ^ set[i].octrl[0]; // see RQ3 see RQ4
            end
            default:   raw_r[i] <= raw_r[i];
          endcase
      end
  end

  // output stage; code 000 keeps the pin low whatever the polarity
  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      raw_compare_reference_o <= '0;
      channel_output_o        <= '0;
      capture_event_o         <= '0;
    end
    else
    begin
      raw_compare_reference_o <= raw_r;
      channel_output_o        <= ref_en_r & (raw_r ^ pol); // see RQ5
      capture_event_o         <= cap_r;
    end
  end

  // capture flags, set wins over a software clear
  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      capflag_r <= '0;
    else
      for (int i = 0; i < CH; i++)
        if (cap_r[i])
          capflag_r[i] <= 1'b1;
        else if (wr_go && aw_r == ADDR_STATUS && ws_r[0] && !wd_r[i])
          capflag_r[i] <= 1'b0;
  end

  // axi write channel: address and data may come in either order
  assign wr_go = (wr_st_r == BUS_HOLD);
  always_comb
    for (int i = 0; i < CH; i++)
      data_wr[i] = wr_go && (aw_r == ADDR_DATA_BASE + 8'(4*i)) && (&ws_r[1:0]);

  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      wr_st_r         <= BUS_IDLE;
      aw_ok_r         <= 1'b0;
      w_ok_r          <= 1'b0;
      aw_r            <= '0;
      wd_r            <= '0;
      ws_r            <= '0;
      s_axi_awready_o <= 1'b0;
      s_axi_wready_o  <= 1'b0;
      s_axi_bvalid_o  <= 1'b0;
      s_axi_bresp_o   <= AXI_OKAY;
    end
    else
      case (wr_st_r)
        BUS_IDLE:
        begin
          s_axi_awready_o <= !aw_ok_r && !(s_axi_awvalid_i && s_axi_awready_o);
          s_axi_wready_o  <= !w_ok_r && !(s_axi_wvalid_i && s_axi_wready_o);
          if (s_axi_awvalid_i && s_axi_awready_o)
          begin
            aw_r    <= s_axi_awaddr_i;
            aw_ok_r <= 1'b1;
          end
          if (s_axi_wvalid_i && s_axi_wready_o)
          begin
            wd_r   <= s_axi_wdata_i;
            ws_r   <= s_axi_wstrb_i;
            w_ok_r <= 1'b1;
          end
          if (aw_ok_r && w_ok_r)
            wr_st_r <= BUS_HOLD;
        end
        BUS_HOLD:
        begin
          aw_ok_r        <= 1'b0;
          w_ok_r         <= 1'b0;
          s_axi_bvalid_o <= 1'b1;
          s_axi_bresp_o  <= (aw_r == ADDR_MODE_FIRST || aw_r == ADDR_MODE_SECOND ||
                             aw_r == ADDR_CTRL || aw_r == ADDR_STATUS ||
                             (aw_r >= ADDR_DATA_BASE && aw_r < ADDR_STATUS &&
                              aw_r[1:0] == 2'b00)) ? AXI_OKAY : AXI_SLVERR;
          wr_st_r        <= BUS_RESP;
        end
        BUS_RESP:
          if (s_axi_bready_i)
          begin
            s_axi_bvalid_o <= 1'b0;
            wr_st_r        <= BUS_IDLE;
          end
        default: wr_st_r <= BUS_IDLE;
      endcase
  end

  // register writes, byte lanes honoured
  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      mode_r[0] <= MODE_RESET;
      mode_r[1] <= MODE_RESET;
      ctrl_r    <= '0;
    end
    else if (wr_go)
      for (int b = 0; b < 2; b++)
        if (ws_r[b])
        begin
          if (aw_r == ADDR_MODE_FIRST)
            mode_r[0][b*8 +: 8] <= wd_r[b*8 +: 8]; // see RQ20
          if (aw_r == ADDR_MODE_SECOND)
            mode_r[1][b*8 +: 8] <= wd_r[b*8 +: 8]; // see RQ20
          if (aw_r == ADDR_CTRL)
            ctrl_r[b*8 +: 8] <= wd_r[b*8 +: 8];
        end
  end

  // read channel: one cycle after address accepted
  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      rd_st_r         <= BUS_IDLE;
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o  <= 1'b0;
      s_axi_rdata_o   <= '0;
      s_axi_rresp_o   <= AXI_OKAY;
    end
    else
      case (rd_st_r)
        BUS_IDLE:
        begin
          s_axi_arready_o <= !(s_axi_arvalid_i && s_axi_arready_o);
          if (s_axi_arvalid_i && s_axi_arready_o)
          begin
            rd_st_r        <= BUS_RESP;
            s_axi_rvalid_o <= 1'b1;
            s_axi_rresp_o  <= AXI_OKAY;
            case (s_axi_araddr_i)
              ADDR_MODE_FIRST:  s_axi_rdata_o <= {16'h0000, mode_r[0]};
              ADDR_MODE_SECOND: s_axi_rdata_o <= {16'h0000, mode_r[1]};
              ADDR_CTRL:        s_axi_rdata_o <= {16'h0000, ctrl_r};
              ADDR_STATUS:      s_axi_rdata_o <= {16'h0000, 4'h0, raw_r, 4'h0, capflag_r};
              8'h10:            s_axi_rdata_o <= {16'h0000, shadow_r[0]};
              8'h14:            s_axi_rdata_o <= {16'h0000, shadow_r[1]};
              8'h18:            s_axi_rdata_o <= {16'h0000, shadow_r[2]};
              8'h1c:            s_axi_rdata_o <= {16'h0000, shadow_r[3]};
              default:
              begin
                s_axi_rdata_o <= '0;
                s_axi_rresp_o <= AXI_SLVERR;
              end
            endcase
          end
        end
        BUS_RESP:
          if (s_axi_rready_i)
          begin
            s_axi_rvalid_o <= 1'b0;
            rd_st_r        <= BUS_IDLE;
          end
        default: rd_st_r <= BUS_IDLE;
      endcase
  end

  // forced level appears two edges after the mode write
  AST_FORCE_HIGH: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    set[0].octrl == OC_HIGH && !(set[0].sw_en && external_clear_input_i)
      |=> raw_r[0]) else $error("forced high not applied"); // see RQ2
  AST_FORCE_LOW: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    set[1].octrl == OC_LOW |=> !raw_r[1]) else $error("forced low not applied"); // see RQ2
  AST_EXT_CLEAR: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    set[0].sw_en && external_clear_input_i |=> !raw_r[0]) else $error("clear ignored"); // see RQ21
  AST_OFF_OUT: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    set[0].octrl == OC_OFF ##1 set[0].octrl == OC_OFF |=> !channel_output_o[0])
    else $error("disconnected output drives"); // see RQ1
  AST_POLARITY: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    ref_en_r[0] |=> channel_output_o[0] == ($past(raw_r[0]) ^ $past(pol[0])))
    else $error("output polarity wrong"); // see RQ5
  AST_PRESCALE_RST: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    !en[0] |=> pre_r[0] == 3'd0) else $error("prescaler not cleared"); // see RQ19
  AST_NO_BUF: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    data_wr[0] && !set[0].buf_en && set[0].cfg == CFG_OUT
      |=> active_r[0] == $past(wd_r[15:0])) else $error("direct write lost"); // see RQ6
  AST_BUF_HOLD: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    set[0].buf_en && !overflow_event_i && !cap_r[0] && !data_wr[0] |=> $stable(active_r[0]))
    else $error("buffered value moved early"); // see RQ7
  AST_CAPTURE: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    cap_r[0] && set[0].cfg != CFG_OUT |=> shadow_r[0] == $past(counter_value_i))
    else $error("capture value wrong"); // see RQ22
  AST_IMMEDIATE: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    set[0].octrl == OC_PWM_A && set[0].imm_en && trigger_event_i &&
      !(set[0].sw_en && external_clear_input_i) |=> raw_r[0])
    else $error("immediate output missing"); // see RQ8
endmodule : chan_mode_ctrl

// ===== logic/chan_mode_pkg.sv
// package for the four-channel capture/compare mode block
// assumes a 32-bit axi4-lite master and a 16-bit counter supplied from outside
package chan_mode_pkg;
  localparam logic [7:0]  ADDR_MODE_FIRST  = 8'h00;
  localparam logic [7:0]  ADDR_MODE_SECOND = 8'h04;
  localparam logic [7:0]  ADDR_CTRL        = 8'h08;
  localparam logic [7:0]  ADDR_DATA_BASE   = 8'h10;
  localparam logic [7:0]  ADDR_STATUS      = 8'h20;
  localparam logic [15:0] MODE_RESET       = 16'h0000;
  localparam logic [15:0] DATA_RESET       = 16'h0000;
  localparam int          CFG_LSB          = 0;
  localparam int          IMM_BIT          = 2;
  localparam int          BUF_BIT          = 3;
  localparam int          OCTRL_LSB        = 4;
  localparam int          SWITCH_BIT       = 7;
  localparam int          DIV_LSB          = 2;
  localparam int          FILT_LSB         = 4;
  localparam int          CTRL_EN_BIT      = 0;
  localparam int          CTRL_POL_BIT     = 1;
  localparam int          CTRL_STRIDE      = 4;
  localparam logic [1:0]  AXI_OKAY         = 2'b00;
  localparam logic [1:0]  AXI_SLVERR       = 2'b10;
  localparam int          DTS_DIV_MAX      = 32;

  typedef enum logic [2:0]
  {
    OC_OFF    = 3'b000,
    OC_SET    = 3'b001,
    OC_CLR    = 3'b010,
    OC_TOGGLE = 3'b011,
    OC_LOW    = 3'b100,
    OC_HIGH   = 3'b101,
    OC_PWM_A  = 3'b110,
    OC_PWM_B  = 3'b111
  } out_ctrl_t;

  typedef enum logic [1:0]
  {
    CFG_OUT   = 2'b00,
    CFG_OWN   = 2'b01,
    CFG_PAIR  = 2'b10,
    CFG_TRIG  = 2'b11
  } chan_cfg_t;

  typedef struct packed
  {
    logic [3:0] filt;
    logic [1:0] div;
    logic       sw_en;
    out_ctrl_t  octrl;
    logic       buf_en;
    logic       imm_en;
    chan_cfg_t  cfg;
  } chan_set_t;

  typedef enum logic [2:0]
  {
    BUS_IDLE = 3'b001,
    BUS_RESP = 3'b010,
    BUS_HOLD = 3'b100
  } bus_state_t;

  // filter sampling divider mask (divider minus one) and count n per filter code
  function automatic logic [5:0] filt_div(input logic [3:0] code);
    case (code)
      4'h0, 4'h1, 4'h2, 4'h3: filt_div = 6'd0;
      4'h4, 4'h5:             filt_div = 6'd1;
      4'h6, 4'h7:             filt_div = 6'd3;
      4'h8, 4'h9:             filt_div = 6'd7;
      4'ha, 4'hb, 4'hc:       filt_div = 6'd15;
      default:                filt_div = 6'd31;
    endcase
  endfunction : filt_div

  function automatic logic [3:0] filt_n(input logic [3:0] code);
    case (code)
      4'h0:                   filt_n = 4'd1;
      4'h1:                   filt_n = 4'd2;
      4'h2:                   filt_n = 4'd4;
      4'h4, 4'h6, 4'h8, 4'hb, 4'he: filt_n = 4'd6;
      4'ha, 4'hd:             filt_n = 4'd5;
      default:                filt_n = 4'd8;
    endcase
  endfunction : filt_n
endpackage : chan_mode_pkg

// ===== tb/pin_drive.sv
// model of the external pins that feed the channel inputs
// assumes the bench sets new pin levels just after a rising clock edge
module pin_drive
(
  // clock
  input  wire logic       ref_clk_i,
  // requested levels and pins
  input  wire logic [3:0] level_i,
  output logic      [3:0] pin_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // one change per clock at most, like a synchronised source
  always_ff @(posedge ref_clk_i)
    pin_o <= level_i;
endmodule : pin_drive

// ===== tb/timer_channel_mode_control_test.sv
// self-checking bench for the channel mode block
// assumes the package offsets and a 10 MHz clock; pins come from pin_drive
module timer_channel_mode_control_test
  import chan_mode_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0, rst_n = 1'b0, ovf = 1'b0, ext_clr = 1'b0;
  logic        dir = 1'b0, trg = 1'b0, strig = 1'b0;
  logic        aw_valid = 1'b0, w_valid = 1'b0, b_ready = 1'b0;
  logic        ar_valid = 1'b0, r_ready = 1'b0;
  logic [7:0]  aw_addr = 8'h00, ar_addr = 8'h00;
  logic [31:0] w_data = 32'h0000_0000;
  logic [15:0] cnt = 16'h0000;
  logic [3:0]  pin_level = 4'h0;
  logic [3:0]  pins, raw, outp;
  logic        aw_rdy, w_rdy, b_valid, ar_rdy, r_valid;
  logic [1:0]  b_resp, r_resp;
  logic [31:0] r_data;
  int          mismatches = 0;
  int          samples_checked = 0;

  initial
  begin
    forever #50 clk = ~clk;
  end

  pin_drive u_pin_drive (.ref_clk_i(clk), .level_i(pin_level), .pin_o(pins));

  chan_mode_ctrl u_chan_mode_ctrl (
    .ref_clk_i(clk), .reset_n_i(rst_n),
    .s_axi_awaddr_i(aw_addr), .s_axi_awvalid_i(aw_valid), .s_axi_awready_o(aw_rdy),
    .s_axi_wdata_i(w_data), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(w_valid),
    .s_axi_wready_o(w_rdy), .s_axi_bresp_o(b_resp), .s_axi_bvalid_o(b_valid),
    .s_axi_bready_i(b_ready), .s_axi_araddr_i(ar_addr), .s_axi_arvalid_i(ar_valid),
    .s_axi_arready_o(ar_rdy), .s_axi_rdata_o(r_data), .s_axi_rresp_o(r_resp),
    .s_axi_rvalid_o(r_valid), .s_axi_rready_i(r_ready),
    .counter_value_i(cnt), .count_direction_i(dir), .overflow_event_i(ovf),
    .trigger_event_i(trg), .dead_time_tick_i(1'b1), .slave_trigger_input_i(strig),
    .external_clear_input_i(ext_clr), .channel_input_signal_i(pins),
    .raw_compare_reference_o(raw), .channel_output_o(outp), .capture_event_o());

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk

  // ready is read at the falling edge, so it is the value the next rising edge samples
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] resp);
    logic ta, tw;
    ta = 1'b0;
    tw = 1'b0;
    @(posedge clk);
    aw_addr <= a;
    w_data <= d;
    aw_valid <= 1'b1;
    w_valid <= 1'b1;
    b_ready <= 1'b1;
    while (!(ta && tw))
    begin
      @(negedge clk);
      ta = ta || aw_rdy;
      tw = tw || w_rdy;
      @(posedge clk);
      if (ta) aw_valid <= 1'b0;
      if (tw) w_valid <= 1'b0;
    end
    do @(negedge clk); while (!b_valid);
    chk(b_resp, resp);
    @(posedge clk);
    b_ready <= 1'b0;
  endtask : wr

  task rd_chk(input logic [7:0] a, input logic [31:0] d, input logic [1:0] resp);
    @(posedge clk);
    ar_addr <= a;
    ar_valid <= 1'b1;
    r_ready <= 1'b1;
    do @(negedge clk); while (!ar_rdy);
    @(posedge clk);
    ar_valid <= 1'b0;
    do @(negedge clk); while (!r_valid);
    chk(r_data, d);
    chk(r_resp, resp);
    @(posedge clk);
    r_ready <= 1'b0;
  endtask : rd_chk

  // compare path takes two edges; margin for the filter and capture too
  task settle;
    repeat (6) @(posedge clk);
    @(negedge clk);
  endtask : settle

  task t_regs;
    rd_chk(ADDR_MODE_FIRST, 32'h0000_0000, AXI_OKAY);
    wr(ADDR_MODE_SECOND, 32'hffff_7351, AXI_OKAY);
    rd_chk(ADDR_MODE_SECOND, 32'h0000_7351, AXI_OKAY);
    wr(8'h3c, 32'h0000_1234, AXI_SLVERR);
    rd_chk(8'h3c, 32'h0000_0000, AXI_SLVERR);
    $display("register test done");
  endtask : t_regs

  task t_force;
    wr(ADDR_MODE_FIRST, 32'h0000_4050, AXI_OKAY);
    wr(ADDR_MODE_SECOND, 32'h0000_0050, AXI_OKAY);
    wr(ADDR_CTRL, 32'h0000_0111, AXI_OKAY);
    settle;
    chk(raw[2:0], 3'b101);
    chk(outp, 4'b0101);
    wr(ADDR_CTRL, 32'h0000_0113, AXI_OKAY);
    settle;
    chk(outp, 4'b0100);
    wr(ADDR_CTRL, 32'h0000_0111, AXI_OKAY);
    wr(ADDR_MODE_FIRST, 32'h0000_4000, AXI_OKAY);
    settle;
    chk(outp[0], 1'b0);
    $display("forced output test done");
  endtask : t_force

  task t_match;
    wr(ADDR_MODE_FIRST, 32'h0000_0040, AXI_OKAY);
    wr(ADDR_CTRL, 32'h0000_0001, AXI_OKAY);
    wr(ADDR_DATA_BASE, 32'h0000_0123, AXI_OKAY);
    wr(ADDR_MODE_FIRST, 32'h0000_0010, AXI_OKAY);
    settle;
    chk(raw[0], 1'b0);
    @(posedge clk);
    cnt <= 16'h0123;
    settle;
    chk(raw[0], 1'b1);
    wr(ADDR_MODE_FIRST, 32'h0000_0090, AXI_OKAY);
    cnt <= 16'h0000;
    ext_clr <= 1'b1;
    settle;
    chk(raw[0], 1'b0);
    wr(ADDR_MODE_FIRST, 32'h0000_0018, AXI_OKAY);
    ext_clr <= 1'b0;
    wr(ADDR_DATA_BASE, 32'h0000_0200, AXI_OKAY);
    cnt <= 16'h0200;
    settle;
    chk(raw[0], 1'b0);
    @(posedge clk);
    ovf <= 1'b1;
    @(posedge clk);
    ovf <= 1'b0;
    settle;
    chk(raw[0], 1'b1);
    $display("compare test done");
  endtask : t_match

  // equal data and counter tells the two count directions apart
  task t_pwm;
    wr(ADDR_MODE_FIRST, 32'h0000_0060, AXI_OKAY);
    wr(ADDR_DATA_BASE, 32'h0000_0300, AXI_OKAY);
    settle;
    chk(outp[0], 1'b1);
    @(posedge clk);
    dir <= 1'b1;
    cnt <= 16'h0300;
    settle;
    chk(outp[0], 1'b1);
    wr(ADDR_MODE_FIRST, 32'h0000_0070, AXI_OKAY);
    settle;
    chk(outp[0], 1'b0);
    wr(ADDR_MODE_FIRST, 32'h0000_0064, AXI_OKAY);
    cnt <= 16'h0400;
    settle;
    chk(raw[0], 1'b0);
    @(posedge clk);
    trg <= 1'b1;
    @(posedge clk);
    trg <= 1'b0;
    @(posedge clk);
    @(negedge clk);
    chk(raw[0], 1'b1);
    $display("pwm test done");
  endtask : t_pwm

  // direction changes only while disabled; also clears the edge count
  task t_capture;
    wr(ADDR_CTRL, 32'h0000_0000, AXI_OKAY);
    wr(ADDR_MODE_FIRST, 32'h0000_0201, AXI_OKAY);
    wr(ADDR_CTRL, 32'h0000_0011, AXI_OKAY);
    cnt <= 16'h0456;
    pin_level <= 4'b0001;
    settle;
    rd_chk(ADDR_DATA_BASE, 32'h0000_0456, AXI_OKAY);
    rd_chk(ADDR_DATA_BASE + 8'h04, 32'h0000_0456, AXI_OKAY);
    wr(ADDR_CTRL, 32'h0000_0000, AXI_OKAY);
    wr(ADDR_MODE_FIRST, 32'h0000_0205, AXI_OKAY);
    wr(ADDR_CTRL, 32'h0000_0011, AXI_OKAY);
    pin_level <= 4'b0000;
    cnt <= 16'h0777;
    settle;
    @(posedge clk);
    pin_level <= 4'b0001;
    settle;
    rd_chk(ADDR_DATA_BASE, 32'h0000_0456, AXI_OKAY);
    pin_level <= 4'b0000;
    cnt <= 16'h0888;
    settle;
    @(posedge clk);
    pin_level <= 4'b0001;
    settle;
    rd_chk(ADDR_DATA_BASE, 32'h0000_0888, AXI_OKAY);
    wr(ADDR_MODE_SECOND, 32'h0000_0300, AXI_OKAY);
    wr(ADDR_CTRL, 32'h0000_1011, AXI_OKAY);
    cnt <= 16'h0999;
    strig <= 1'b1;
    settle;
    rd_chk(ADDR_DATA_BASE + 8'h0c, 32'h0000_0999, AXI_OKAY);
    $display("capture test done");
  endtask : t_capture

  task test_done;
    $display("checks %0d, mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : test_done

  initial
  begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    t_regs;
    t_force;
    t_match;
    t_pwm;
    t_capture;
    test_done;
  end

  // the whole run needs well under 2000 cycles
  initial
  begin
    repeat (20000) @(posedge clk);
    mismatches++;
    test_done;
  end
endmodule : timer_channel_mode_control_test
